// ### cdi_if.sv
// Link between the sample source and the channelizer input port
interface cdi_if;
   // Sample clock, made by the source
   logic input_sample_clock;
   // Data pins, one bit per pin or differential pair
   logic [31:0] data;
   // Marks the link cycle that carries the first word of an update
   logic frame;

   // Source drives everything
   modport source (
      output input_sample_clock,
      output data,
      output frame
   );
   // Port only listens
   modport port (
      input input_sample_clock,
      input data,
      input frame
   );
endinterface

// ### cdi_link_checker.sv
// Checker on the link between the sample source and the input port
module cdi_link_checker (
   // Link
   input wire logic input_sample_clock,
   input wire logic [31:0] data,
   input wire logic frame,
   // Port reset and configuration
   input wire logic rst_in,
   input wire logic [1:0] bus_width_select_in,
   input wire logic complex_in,
   input wire logic wide_in,
   input wire logic lvds_in,
   // Port status
   input wire logic update_valid_out,
   input wire logic locked_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import cdi_pkg::*;
   logic [5:0] upd_n; // Link cycles per update
   logic [31:0] msk; // Pins the source may drive
   logic ill; // Unsupported width and format pair
   logic last; // Rising edge carrying the last piece
   logic [5:0] cnt_ff; // Link cycles since the last frame
   logic [5:0] nxt_cnt;
   logic seen_ff; // Frame seen since reset
   logic [31:0] rise_ff; // Word held at the rising edge
   // Mode geometry and frame counting
   always_comb begin
      upd_n = (!complex_in ? 6'h08 : wide_in ? 6'h20 : 6'h10)
         >> bus_width_select_in;
      case (bus_width_select_in)
         2'h0: msk = CDI_MASK_4;
         2'h1: msk = CDI_MASK_8;
         2'h2: msk = CDI_MASK_16;
         default: msk = lvds_in ? CDI_MASK_16 : CDI_MASK_32;
      endcase
      ill = wide_in && (!complex_in || bus_width_select_in == 2'h0);
      // One-cycle updates end on the frame cycle itself
      last = (upd_n == 6'h01) ? frame
         : (seen_ff && !frame && cnt_ff == upd_n - 6'h02);
      // Saturate so a long idle never wraps into a false match
      nxt_cnt = frame ? 6'h00 : (cnt_ff == 6'h3F ? cnt_ff : cnt_ff + 6'h01);
   end
   // Async reset: the link clock may stand still while reset is high
   always_ff @(posedge input_sample_clock or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff <= 6'h00;
         seen_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         seen_ff <= seen_ff | frame;
      end
   end
   // Word at the rising edge, for the falling edge compare
   always_ff @(posedge input_sample_clock) begin
      rise_ff <= data;
   end
   a_upper_pins_idle: assert property (
      @(posedge input_sample_clock) disable iff (rst_in)
      (data & ~msk) == 32'h0) else $error("Pin above width driven");
   a_frame_spacing: assert property (
      @(posedge input_sample_clock) disable iff (rst_in)
      frame && seen_ff |-> cnt_ff == upd_n - 6'h01)
      else $error("Frame spacing wrong");
   a_nibble_eight: assert property (
      @(posedge input_sample_clock) disable iff (rst_in)
      frame && bus_width_select_in == 2'h0 && !complex_in
      |=> !frame [*7] ##1 frame) else $error("Nibble update not 8 cycles");
   a_update_after_last: assert property (
      @(posedge input_sample_clock) disable iff (rst_in)
      last && locked_out |-> ##[1:2] update_valid_out)
      else $error("No update after last piece");
   a_illegal_silent: assert property (
      @(posedge input_sample_clock) disable iff (rst_in)
      ill |-> !update_valid_out && !locked_out)
      else $error("Port active on illegal mode");
   a_illegal_idle: assert property (
      @(posedge input_sample_clock) disable iff (rst_in)
      ill |-> data == 32'h0 && !frame) else $error("Link busy on illegal");
   a_single_rate: assert property (
      @(negedge input_sample_clock) disable iff (rst_in)
      !(lvds_in && bus_width_select_in == 2'h3) |-> data == rise_ff)
      else $error("Data moved within a single rate cycle");
   a_ddr_pairs_only: assert property (
      @(negedge input_sample_clock) disable iff (rst_in)
      lvds_in && bus_width_select_in == 2'h3 |-> data[31:16] == 16'h0)
      else $error("Upper pairs used in double rate");
endmodule

// ### cdi_pkg.sv
// Shared constants, types and decoders of the channelizer data input link
package cdi_pkg;
   // Link and sample geometry
   localparam int CDI_CHANNELS = 4; // Channels per update
   localparam int CDI_PIN_W = 32; // Data pins on the link
   localparam int CDI_LVDS_PAIRS = 16; // Pairs used in the double rate mode
   localparam int CDI_SAMPLE_W = 16; // Width of one user sample
   localparam int CDI_NIB_W = 4; // Packing unit on the link
   localparam int CDI_BUF_NIBS = 32; // Nibbles of the largest update
   localparam int CDI_BUF_W = CDI_BUF_NIBS * CDI_NIB_W; // Update buffer
   localparam int CDI_MAX_WORD_NIBS = 8; // Nibbles in one link cycle
   // Bus width select codes
   localparam logic [1:0] CDI_BW_4 = 2'h0;
   localparam logic [1:0] CDI_BW_8 = 2'h1;
   localparam logic [1:0] CDI_BW_16 = 2'h2;
   localparam logic [1:0] CDI_BW_32 = 2'h3;
   // Nibble counts
   localparam logic [5:0] CDI_NIBS_REAL8 = 6'h08;
   localparam logic [5:0] CDI_NIBS_CPLX8 = 6'h10;
   localparam logic [5:0] CDI_NIBS_CPLX16 = 6'h20;
   localparam logic [5:0] CDI_NIBS_HALF = 6'h04; // One double rate half
   // Pin masks per bus width
   localparam logic [31:0] CDI_MASK_4 = 32'h0000000F;
   localparam logic [31:0] CDI_MASK_8 = 32'h000000FF;
   localparam logic [31:0] CDI_MASK_16 = 32'h0000FFFF;
   localparam logic [31:0] CDI_MASK_32 = 32'hFFFFFFFF;
   // Timing: system clock and the divided link clock of the source
   localparam int CDI_CLK_NS = 50; // clock_in period
   localparam int CDI_LINK_DIV = 4; // clock_in cycles per link cycle
   localparam int CDI_LINK_NS = CDI_CLK_NS * CDI_LINK_DIV;
   localparam logic [1:0] CDI_PH_RISE_DATA = 2'h1; // Data for rising edge
   localparam logic [1:0] CDI_PH_FALL_DATA = 2'h3; // Data for falling edge
   // Sample set handed between user logic and either end
   typedef logic [CDI_CHANNELS-1:0][CDI_SAMPLE_W-1:0] cdi_chan_t;

   // Nibbles the device takes per link cycle
   function automatic logic [5:0] cdi_word_nibs(input logic [1:0] bw);
      case (bw)
         CDI_BW_4: cdi_word_nibs = 6'h01;
         CDI_BW_8: cdi_word_nibs = 6'h02;
         CDI_BW_16: cdi_word_nibs = 6'h04;
         default: cdi_word_nibs = 6'h08;
      endcase
   endfunction

   // Nibbles in one full update of all channels
   function automatic logic [5:0] cdi_update_nibs(input logic cplx,
                                                  input logic wide);
      if (!cplx) begin
         cdi_update_nibs = CDI_NIBS_REAL8;
      end else if (wide) begin
         cdi_update_nibs = CDI_NIBS_CPLX16;
      end else begin
         cdi_update_nibs = CDI_NIBS_CPLX8;
      end
   endfunction

   // Only the supported width and format pairs are legal
   function automatic logic cdi_cfg_legal(input logic [1:0] bw,
                                          input logic cplx,
                                          input logic wide);
      cdi_cfg_legal = !(wide && !cplx) && !(wide && bw == CDI_BW_4);
   endfunction

   // Double data rate applies only to the widest differential bus
   function automatic logic cdi_is_ddr(input logic [1:0] bw,
                                       input logic lvds);
      cdi_is_ddr = lvds && bw == CDI_BW_32;
   endfunction
endpackage

// ### cdi_port.sv
// Channelizer data input port: captures link words into channel samples
module cdi_port (
   // Link
   cdi_if.port link,
   // Reset, taken into the link clock domain
   input wire logic rst_in,
   // Configuration, static while streaming
   input wire logic [1:0] bus_width_select_in,
   input wire logic complex_in,
   input wire logic wide_in,
   input wire logic lvds_in,
   // Channel samples
   output cdi_pkg::cdi_chan_t sample_i_out,
   output cdi_pkg::cdi_chan_t sample_q_out,
   output logic update_valid_out,
   // Status
   output logic locked_out,
   output logic config_error_out
);
   import cdi_pkg::*;

   typedef enum logic [1:0] {
      ST_HUNT = 2'b01,
      ST_LOCK = 2'b10
   } cdi_port_st_t;

   // Synchronisers for the reset and the configuration inputs
   logic [1:0] rst_sync_ff; // Stage 0 feeds stage 1 only
   logic [4:0] cfg_meta_ff; // First stage of the configuration
   logic [4:0] cfg_ff; // Settled configuration
   logic rst;
   logic [1:0] bw;
   logic cplx, wide, lvds;

   // Capture stage
   logic [31:0] rise_ff, nxt_rise; // Rising edge word
   logic [15:0] fall_ff, nxt_fall; // Falling edge half word
   logic frame_ff, nxt_frame;

   // Assembly stage
   cdi_port_st_t state_ff, nxt_state;
   logic [CDI_BUF_W-1:0] buf_ff, nxt_buf;
   logic [5:0] cnt_ff, nxt_cnt; // Nibbles gathered so far
   cdi_chan_t i_ff, nxt_i, q_ff, nxt_q;
   logic valid_ff, nxt_valid;
   logic err_ff, nxt_err;
   logic locked_ff, nxt_locked; // Lock flag, kept in a flop for the output
   logic legal, active, done;
   logic [31:0] word;
   logic [5:0] base, word_nibs, tot_nibs, rel;

   // Pin mask for the selected width
   function automatic logic [31:0] pin_mask(input logic [1:0] code,
                                            input logic diff);
      case (code)
         CDI_BW_4: pin_mask = CDI_MASK_4;
         CDI_BW_8: pin_mask = CDI_MASK_8;
         CDI_BW_16: pin_mask = CDI_MASK_16;
         default: pin_mask = diff ? CDI_MASK_16 : CDI_MASK_32;
      endcase
   endfunction

   // Two flops before anything reads the reset or the configuration
   always_ff @(posedge link.input_sample_clock) begin
      rst_sync_ff <= {rst_sync_ff[0], rst_in};
      cfg_meta_ff <= {bus_width_select_in, complex_in, wide_in, lvds_in};
      cfg_ff <= cfg_meta_ff;
   end

   // Unpack the settled configuration
   always_comb begin
      rst = rst_sync_ff[1];
      bw = cfg_ff[4:3];
      cplx = cfg_ff[2];
      wide = cfg_ff[1];
      lvds = cfg_ff[0];
   end

   // Pin capture; unused pins are masked off at the capture flop
   always_comb begin
      nxt_rise = link.data & pin_mask(bw, lvds);
      nxt_fall = link.data[15:0];
      nxt_frame = link.frame;
   end

   // Rising edge capture, once per link cycle in every mode
   always_ff @(posedge link.input_sample_clock) begin
      if (rst) begin
         rise_ff <= '0;
         frame_ff <= 1'b0;
      end else begin
         rise_ff <= nxt_rise;
         frame_ff <= nxt_frame;
      end
   end

   // Falling edge capture, read only in the double rate mode
   always_ff @(negedge link.input_sample_clock) begin
      fall_ff <= nxt_fall;
   end

   // Word assembly, channel steering and lock tracking
   always_comb begin
      legal = cdi_cfg_legal(bw, cplx, wide);
      // The falling half lands above the rising half of the same cycle
      if (cdi_is_ddr(bw, lvds)) begin
         word = {fall_ff, rise_ff[15:0]};
      end else begin
         word = rise_ff;
      end
      word_nibs = cdi_word_nibs(bw);
      tot_nibs = cdi_update_nibs(cplx, wide);
      // A frame restarts the gathering whatever the count says
      base = frame_ff ? 6'h00 : cnt_ff;
      active = legal && (state_ff == ST_LOCK || frame_ff);
      done = base + word_nibs >= tot_nibs;
      nxt_buf = buf_ff;
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_valid = 1'b0;
      nxt_err = !legal;
      nxt_i = i_ff;
      nxt_q = q_ff;
      rel = 6'h00;
      // Place this word's nibbles after those already gathered
      for (int n = 0; n < CDI_BUF_NIBS; n++) begin
         rel = 6'(n) - base;
         if (6'(n) >= base && 6'(n) < base + word_nibs) begin
            nxt_buf[n*4 +: 4] = word[{rel[2:0], 2'b00} +: 4];
         end
      end
      if (!legal) begin
         // Unsupported layout: drop lock and discard the partial set
         nxt_state = ST_HUNT;
         nxt_cnt = 6'h00;
         nxt_buf = buf_ff;
      end else if (!active) begin
         // Hunting: wait for a frame before trusting the word order
         nxt_buf = buf_ff;
      end else begin
         nxt_state = ST_LOCK;
         if (done) begin
            nxt_cnt = 6'h00;
            nxt_valid = 1'b1;
            // Steer each byte or half word to its channel
            for (int c = 0; c < CDI_CHANNELS; c++) begin
               if (cplx && wide) begin
                  nxt_i[c] = nxt_buf[c*32 +: 16];
                  nxt_q[c] = nxt_buf[c*32+16 +: 16];
               end else if (cplx) begin
                  nxt_i[c] = {nxt_buf[c*16 +: 8], 8'h00};
                  nxt_q[c] = {nxt_buf[c*16+8 +: 8], 8'h00};
               end else begin
                  // Real data has no quadrature part
                  nxt_i[c] = {nxt_buf[c*8 +: 8], 8'h00};
                  nxt_q[c] = 16'h0000;
               end
            end
         end else begin
            nxt_cnt = base + word_nibs;
         end
      end
      // Lock follows the next state so the output needs no decode
      nxt_locked = nxt_state == ST_LOCK;
   end

   // Assembly registers
   always_ff @(posedge link.input_sample_clock) begin
      if (rst) begin
         state_ff <= ST_HUNT;
         buf_ff <= '0;
         cnt_ff <= 6'h00;
         i_ff <= '0;
         q_ff <= '0;
         valid_ff <= 1'b0;
         err_ff <= 1'b0;
         locked_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         buf_ff <= nxt_buf;
         cnt_ff <= nxt_cnt;
         i_ff <= nxt_i;
         q_ff <= nxt_q;
         valid_ff <= nxt_valid;
         err_ff <= nxt_err;
         locked_ff <= nxt_locked;
      end
   end

   // All outputs come straight from flops
   assign sample_i_out = i_ff;
   assign sample_q_out = q_ff;
   assign update_valid_out = valid_ff;
   assign locked_out = locked_ff;
   assign config_error_out = err_ff;
endmodule

// ### cdi_source.sv
// Data source end: packs sample sets and drives them over the link
module cdi_source (
   // Link
   cdi_if.source link,
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Configuration
   input wire logic [1:0] bus_width_select_in,
   input wire logic complex_in,
   input wire logic wide_in,
   input wire logic lvds_in,
   // Sample set offered by user logic
   input wire cdi_pkg::cdi_chan_t sample_i_in,
   input wire cdi_pkg::cdi_chan_t sample_q_in,
   input wire logic valid_in,
   // Handshake and status
   output logic taken_out,
   output logic config_error_out
);
   import cdi_pkg::*;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_RUN = 2'b10
   } cdi_tx_st_t;

   cdi_tx_st_t state_ff, nxt_state; // Idle until the first set is taken
   logic [1:0] phase_ff, nxt_phase; // Divider phase of the link clock
   logic clk_ff, nxt_clk; // Link clock out
   logic [31:0] data_ff, nxt_data; // Data pins out
   logic frame_ff, nxt_frame; // Frame out
   logic [CDI_BUF_W-1:0] buf_ff, nxt_buf; // Set being repeated
   logic [5:0] pos_ff, nxt_pos; // Next nibble to send
   logic taken_ff, nxt_taken;
   logic err_ff, nxt_err;
   logic legal, ddr, slot_r, slot_f, take;
   logic [5:0] piece_nibs, tot_nibs;
   logic [5:0] idx; // Nibble index into the set
   logic [CDI_BUF_W-1:0] packed_set, src;

   // Pack user samples into link order, channel 0 lowest
   always_comb begin
      packed_set = '0;
      for (int c = 0; c < CDI_CHANNELS; c++) begin
         if (complex_in && wide_in) begin
            packed_set[c*32 +: 16] = sample_i_in[c];
            packed_set[c*32+16 +: 16] = sample_q_in[c];
         end else if (complex_in) begin
            packed_set[c*16 +: 8] = sample_i_in[c][15:8];
            packed_set[c*16+8 +: 8] = sample_q_in[c][15:8];
         end else begin
            // Real sets use the upper byte of the in-phase lane
            packed_set[c*8 +: 8] = sample_i_in[c][15:8];
         end
      end
   end

   // Divider, slot timing and piece selection
   always_comb begin
      legal = cdi_cfg_legal(bus_width_select_in, complex_in, wide_in);
      ddr = cdi_is_ddr(bus_width_select_in, lvds_in);
      // Each double rate edge carries half a word
      piece_nibs = ddr ? CDI_NIBS_HALF : cdi_word_nibs(bus_width_select_in);
      tot_nibs = cdi_update_nibs(complex_in, wide_in);
      nxt_phase = phase_ff + 2'h1;
      nxt_clk = nxt_phase[1];
      // Data changes mid-phase so it is stable around both clock edges
      slot_r = nxt_phase == CDI_PH_RISE_DATA;
      slot_f = ddr && nxt_phase == CDI_PH_FALL_DATA;
      // A new set starts only on a rising edge slot with the set finished
      take = slot_r && pos_ff == 6'h00 && valid_in && legal;
      src = take ? packed_set : buf_ff;
      nxt_buf = src;
      nxt_state = state_ff;
      nxt_data = data_ff;
      nxt_frame = frame_ff;
      nxt_pos = pos_ff;
      nxt_taken = take;
      nxt_err = !legal;
      idx = 6'h00;
      if (!legal) begin
         // Refuse to stream an unsupported layout
         nxt_state = TX_IDLE;
         nxt_data = '0;
         nxt_frame = 1'b0;
         nxt_pos = 6'h00;
      end else if ((slot_r || slot_f) && (state_ff == TX_RUN || take)) begin
         nxt_state = TX_RUN;
         nxt_data = '0; // Pins above the piece stay low
         for (int n = 0; n < CDI_MAX_WORD_NIBS; n++) begin
            idx = pos_ff + 6'(n);
            if (6'(n) < piece_nibs) begin
               nxt_data[n*4 +: 4] = src[{idx[4:0], 2'b00} +: 4];
            end
         end
         if (slot_r) begin
            nxt_frame = pos_ff == 6'h00;
         end
         // Whole update spread over one or more cycles
         if (pos_ff + piece_nibs >= tot_nibs) begin
            nxt_pos = 6'h00;
         end else begin
            nxt_pos = pos_ff + piece_nibs;
         end
      end
   end

   // Registers; the divider also stops in reset, so the link clock is low
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_ff <= TX_IDLE;
         phase_ff <= 2'h0;
         clk_ff <= 1'b0;
         data_ff <= '0;
         frame_ff <= 1'b0;
         buf_ff <= '0;
         pos_ff <= 6'h00;
         taken_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         clk_ff <= nxt_clk;
         data_ff <= nxt_data;
         frame_ff <= nxt_frame;
         buf_ff <= nxt_buf;
         pos_ff <= nxt_pos;
         taken_ff <= nxt_taken;
         err_ff <= nxt_err;
      end
   end

   assign link.input_sample_clock = clk_ff;
   assign link.data = data_ff;
   assign link.frame = frame_ff;
   assign taken_out = taken_ff;
   assign config_error_out = err_ff;
endmodule

// ### test_channelizer_data_input_port.sv
// Bench: source and port joined end to end over the link
module test_channelizer_data_input_port;
   timeunit 1ns;
   timeprecision 1ns;
   import cdi_pkg::*;
   logic clock_in = 1'b0; // System clock
   logic src_rst = 1'b1; // Source reset
   logic port_rst = 1'b1; // Port reset, released after the source
   logic [1:0] bw = 2'h0; // Bus width code
   logic cx = 1'b0; // Complex format
   logic wd = 1'b0; // 16-bit samples
   logic lv = 1'b0; // Differential signaling
   cdi_chan_t si = '0; // Offered in-phase set
   cdi_chan_t sq = '0; // Offered quadrature set
   logic vld = 1'b0; // Set offered
   logic taken, serr, uv, lock, perr;
   cdi_chan_t pi, pq;
   logic [127:0] got[$]; // Updates seen at the port
   int fail_count = 0;
   int check_count = 0;
   cdi_if link();
   always #25 clock_in = ~clock_in;
   cdi_source u_cdi_source (.link(link.source), .clock_in(clock_in),
      .rst_in(src_rst), .bus_width_select_in(bw), .complex_in(cx),
      .wide_in(wd), .lvds_in(lv), .sample_i_in(si), .sample_q_in(sq),
      .valid_in(vld), .taken_out(taken), .config_error_out(serr));
   cdi_port u_cdi_port (.link(link.port), .rst_in(port_rst),
      .bus_width_select_in(bw), .complex_in(cx), .wide_in(wd),
      .lvds_in(lv), .sample_i_out(pi), .sample_q_out(pq),
      .update_valid_out(uv), .locked_out(lock), .config_error_out(perr));
   cdi_link_checker u_cdi_link_checker (
      .input_sample_clock(link.input_sample_clock), .data(link.data),
      .frame(link.frame), .rst_in(port_rst), .bus_width_select_in(bw),
      .complex_in(cx), .wide_in(wd), .lvds_in(lv),
      .update_valid_out(uv), .locked_out(lock));
   // Log updates at the falling edge, where port outputs are settled
   always @(negedge link.input_sample_clock) begin
      if (uv === 1'b1) begin
         got.push_back({pi, pq});
      end
   end
   // Sample pattern; low byte nonzero so 8-bit modes must drop it
   function automatic logic [15:0] pat(input int k, input int c);
      pat = {8'h11 * 8'(k) + 8'h02 * 8'(c) + 8'h01, 8'hC3 ^ 8'(c)};
   endfunction
   // Expected port outputs for set k
   function automatic logic [127:0] exp_set(input int k, input logic c,
                                           input logic w);
      cdi_chan_t ei, eq;
      logic [15:0] vi, vq;
      for (int n = 0; n < CDI_CHANNELS; n++) begin
         vi = pat(k, n);
         vq = pat(k + 8, n);
         ei[n] = w ? vi : {vi[15:8], 8'h00};
         eq[n] = !c ? 16'h0000 : w ? vq : {vq[15:8], 8'h00};
      end
      exp_set = {ei, eq};
   endfunction
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Both ends reset with a new mode; the port needs a running link clock
   task automatic restart(input logic [1:0] b, input logic c, input logic w,
                          input logic l);
      @(posedge clock_in);
      src_rst <= 1'b1;
      port_rst <= 1'b1;
      vld <= 1'b0;
      bw <= b;
      cx <= c;
      wd <= w;
      lv <= l;
      repeat (5) @(posedge clock_in);
      src_rst <= 1'b0;
      repeat (24) @(posedge clock_in);
      port_rst <= 1'b0;
      repeat (16) @(posedge clock_in);
      got.delete();
   endtask
   // Offer set k and wait, bounded, for the source to take it
   task automatic offer(input int k);
      cdi_chan_t ti, tq;
      int n;
      for (int c = 0; c < CDI_CHANNELS; c++) begin
         ti[c] = pat(k, c);
         tq[c] = pat(k + 8, c);
      end
      @(posedge clock_in);
      si <= ti;
      sq <= tq;
      vld <= 1'b1;
      n = 0;
      do begin
         @(negedge clock_in);
         n++;
      end while (taken !== 1'b1 && n < 400);
   endtask
   // Two sets back to back, then idle so the last set repeats
   task automatic run_mode(input logic [1:0] b, input logic c,
                           input logic w, input logic l);
      int n;
      restart(b, c, w, l);
      offer(1);
      offer(2);
      @(posedge clock_in);
      vld <= 1'b0;
      n = 0;
      while (got.size() < 3 && n < 800) begin
         @(posedge clock_in);
         n++;
      end
      check(128'(got.size() >= 3), 128'h1);
      check({125'h0, serr, perr, lock}, 128'h1);
      check(got[0], exp_set(1, c, w));
      check(got[1], exp_set(2, c, w));
      check(got[2], exp_set(2, c, w));
      $display("mode bw=%h cplx=%b wide=%b lvds=%b done", b, c, w, l);
   endtask
   // Unsupported pair: nothing taken, both ends flag it
   task automatic run_illegal(input logic [1:0] b, input logic c);
      restart(b, c, 1'b1, 1'b0);
      offer(3);
      check({126'h0, serr, perr}, 128'h3);
      check(128'(got.size()), 128'h0);
      check({127'h0, lock}, 128'h0);
      $display("illegal bw=%h cplx=%b done", b, c);
   endtask
   task automatic final_report();
      $display("checks=%0d failures=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Every legal width, format and signaling mode, then the refusals
   initial begin
      for (int b = 0; b < 4; b++) begin
         for (int m = 0; m < 8; m++) begin
            if (!(m[1] && (!m[0] || b == 0))) begin
               run_mode(2'(b), m[0], m[1], m[2]);
            end
         end
      end
      run_illegal(2'h0, 1'b1);
      run_illegal(2'h1, 1'b0);
      final_report();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge clock_in);
      fail_count++;
      final_report();
   end
endmodule
